// ### logic/cmb_pkg.sv
package cmb_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int NUM_BUFFERS = 15;
    localparam int SHARED_BUFFERS = 14; // buffers on the shared mask
    localparam int COPY_CYCLES = 17; // least hidden-buffer copy length

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] OFS_CONFIG = 12'h000; // lock-on-first setting
    localparam logic [11:0] OFS_SHARED_MASK = 12'h004;
    localparam logic [11:0] OFS_CATCHALL_MASK = 12'h008;
    localparam logic [11:0] OFS_ENGINE_STATE = 12'h00C; // read only
    localparam logic [11:0] OFS_STATUS_BASE = 12'h040; // status of buffer n at base+4n
    localparam logic [11:0] OFS_ID_BASE = 12'h080; // identifier of buffer n at base+4n

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int CFG_LOCK_BIT = 0;
    localparam int STS_PRIO_LSB = 4; // tx_priority_code, 4 bits
    localparam int STS_NOTIFY_BIT = 8; // received-frame notify enable
    localparam int ID_RTR_BIT = 31;
    localparam int STS_BUSY_BIT = 0;
    localparam int STS_TX_BIT = 3;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    localparam logic [31:0] ID_RESET = 32'h0000_0000;

    // ----------------------------------------------------------------
    // status_code_field encodings
    // ----------------------------------------------------------------
    localparam logic [3:0] ST_RX_IDLE = 4'h0;
    localparam logic [3:0] ST_RX_ARMED = 4'h2;
    localparam logic [3:0] ST_RX_HOLDING = 4'h4;
    localparam logic [3:0] ST_RX_OVERWRITTEN = 4'h6;
    localparam logic [3:0] ST_TX_IDLE = 4'h8;
    localparam logic [3:0] ST_TX_AWAIT_REMOTE = 4'hA;
    localparam logic [3:0] ST_TX_SINGLE_SHOT = 4'hC;
    localparam logic [3:0] ST_TX_SEND_THEN_AWAIT = 4'hE;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [31:0] id_word; // identifier with rtr in the top bit
        logic valid;
    } cmb_frame_type;

    typedef struct packed {
        logic [11:0] addr;
        logic write;
        logic active;
    } cmb_addr_phase_type;

endpackage

// ### logic/cmb_accept_match.sv
`timescale 1ns/10ps
// per-buffer acceptance compare with first-match search
module cmb_accept_match #(
    parameter int NBUF = cmb_pkg::NUM_BUFFERS
) (
    input wire logic [31:0] frame_id,
    input wire logic [NBUF*32-1:0] buf_ids,
    input wire logic [31:0] shared_mask,
    input wire logic [31:0] catchall_mask,
    input wire logic [NBUF-1:0] rx_ok,
    input wire logic [NBUF-1:0] remote_ok,
    output logic rx_hit,
    output logic [3:0] rx_idx,
    output logic [NBUF-1:0] remote_hits
);
    logic [NBUF-1:0] id_hit; // identifier equal outside don't-care bits
    logic [NBUF-1:0] rx_cand;

    // ----------
    // compare per buffer
    // ----------
    for (genvar i = 0; i < NBUF; i++) begin : g_cmp
        // last buffer uses the catch-all mask, others the shared one
        logic [31:0] m;
        assign m = (i == NBUF - 1) ? catchall_mask : shared_mask;
        assign id_hit[i] = ((frame_id ^ buf_ids[i*32 +: 32]) & ~m) == 32'h0000_0000;
    end

    assign rx_cand = id_hit & rx_ok;
    assign remote_hits = id_hit & remote_ok;

    // ----------
    // lowest index wins, catch-all buffer last
    // ----------
    always_comb begin
        rx_hit = 1'b0;
        rx_idx = 4'h0;
        for (int i = NBUF - 1; i >= 0; i--) begin
            if (rx_cand[i]) begin
                rx_hit = 1'b1;
                rx_idx = 4'(i);
            end
        end
    end

endmodule // cmb_accept_match

// ### logic/cmb_buffer_ctrl.sv
// The placing of the registers and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/10ps
// How it works
// - reception starts on dominant bit, hidden buffer
// - match buffers, copy after sixth EOF bit
// - copy lasts at least 17 clocks
// - busy bit set during the copy
// - busy cleared after copy, then rx_holding
// - second frame before rearm gives rx_overwritten
// - status written mid-copy resolved by table
// - only status code writes accepted while busy
// - rx_idle 0000, rx_armed 0010, rx_holding 0100
// - copy into holding buffer shows 0101
// - status bit 3 selects transmit buffer
// - single shot shows in-progress, then tx_idle
// - failed transmission retried until sent or cancelled
// - sent remote request moves buffer to rx_armed
// - remote frame triggers await buffer send, restore
// - send-then-await transmits, then awaits remote
// - enabled buffer signals on entering rx_holding
// - lock-on-first holds buffer until rearmed
// - buffers 0-13 ascending first, 14 last
// - shared mask ones are don't-care bits
module cmb_buffer_ctrl #(
    parameter int NBUF = cmb_pkg::NUM_BUFFERS
) (
    input wire logic ref_clk,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // can link side
    input wire logic rx_sof,
    input wire logic rx_eof6,
    input wire logic [31:0] rx_id_word,
    input wire logic tx_ok,
    input wire logic tx_fail,
    output logic tx_req,
    output logic [3:0] tx_buf,
    output logic [31:0] tx_id_word,
    output logic rx_busy,
    output logic rx_notify,
    output logic [3:0] rx_notify_buf
);
    // ----------
    // elaboration check
    // ----------
    if (NBUF < 2 || NBUF > 16) begin : g_bad_nbuf
        $error("buffer count must be 2 to 16");
    end

    localparam logic [4:0] COPY_LAST = 5'(cmb_pkg::COPY_CYCLES - 1);

    // ----------
    // storage
    // ----------
    logic [8:0] status_q [NBUF]; // notify, priority, status code
    logic [31:0] id_q [NBUF]; // identifier words
    logic lock_q; // receive_lock_on_first
    logic [31:0] shared_mask_q;
    logic [31:0] catchall_mask_q;
    cmb_pkg::cmb_addr_phase_type ap_q; // pending data phase
    cmb_pkg::cmb_frame_type hidden_q; // hidden receive buffer
    logic receiving_q; // frame in progress on bus
    logic copy_q; // copy in progress
    logic [3:0] copy_buf_q;
    logic [4:0] copy_cnt_q;
    logic tx_active_q;
    logic [3:0] tx_buf_q;
    assign tx_buf = tx_buf_q; // port shows the sender flop

    // ----------
    // bus decode
    // ----------
    logic addr_take; // address phase accepted
    logic wr_now; // data phase write this cycle
    logic wr_status; // write hits a status word
    logic wr_id;
    logic [3:0] wr_idx;
    logic copy_done;
    logic [2:0] base_code; // status code bits 3..1 seen at copy end

    assign addr_take = hsel && hready && htrans[1];
    assign wr_now = ap_q.active && ap_q.write;
    assign wr_idx = ap_q.addr[5:2];
    assign wr_status = wr_now && ap_q.addr[11:6] == cmb_pkg::OFS_STATUS_BASE[11:6] && 32'(wr_idx) < NBUF;
    assign wr_id = wr_now && ap_q.addr[11:6] == cmb_pkg::OFS_ID_BASE[11:6] && 32'(wr_idx) < NBUF;
    assign copy_done = copy_q && copy_cnt_q == COPY_LAST;
    assign base_code = (wr_status && wr_idx == copy_buf_q) ? hwdata[3:1] : status_q[copy_buf_q][3:1];

    // ----------
    // acceptance
    // ----------
    logic [NBUF*32-1:0] ids_flat;
    logic [NBUF-1:0] rx_ok;
    logic [NBUF-1:0] remote_ok;
    logic rx_hit;
    logic [3:0] rx_idx;
    logic [NBUF-1:0] remote_hits;

    for (genvar i = 0; i < NBUF; i++) begin : g_elig
        logic [3:0] st;
        assign st = status_q[i][3:0];
        assign ids_flat[i*32 +: 32] = id_q[i];
        // receive buffers armed, holding or overwritten; locked ones skipped
        assign rx_ok[i] = !st[cmb_pkg::STS_TX_BIT] && st != cmb_pkg::ST_RX_IDLE
            && !(lock_q && st != cmb_pkg::ST_RX_ARMED);
        assign remote_ok[i] = hidden_q.id_word[cmb_pkg::ID_RTR_BIT]
            && st == cmb_pkg::ST_TX_AWAIT_REMOTE;
    end

    cmb_accept_match #(
        .NBUF(NBUF)
    ) u_match (
        .frame_id(hidden_q.id_word),
        .buf_ids(ids_flat),
        .shared_mask(shared_mask_q),
        .catchall_mask(catchall_mask_q),
        .rx_ok(rx_ok),
        .remote_ok(remote_ok),
        .rx_hit(rx_hit),
        .rx_idx(rx_idx),
        .remote_hits(remote_hits)
    );

    logic start_copy;
    assign start_copy = hidden_q.valid && !copy_q && rx_hit;

    // ----------
    // transmit selection: lowest pending request
    // ----------
    logic tx_pick;
    logic [3:0] tx_pick_idx;
    always_comb begin
        tx_pick = 1'b0;
        tx_pick_idx = 4'h0;
        for (int i = NBUF - 1; i >= 0; i--) begin
            if (status_q[i][3:0] == cmb_pkg::ST_TX_SINGLE_SHOT
                    || status_q[i][3:0] == cmb_pkg::ST_TX_SEND_THEN_AWAIT) begin
                tx_pick = 1'b1;
                tx_pick_idx = 4'(i);
            end
        end
    end

    logic tx_cancel; // software wrote a non-request code to the sender
    assign tx_cancel = tx_active_q && wr_status && wr_idx == tx_buf_q
        && hwdata[3:1] != cmb_pkg::ST_TX_SINGLE_SHOT[3:1]
        && hwdata[3:1] != cmb_pkg::ST_TX_SEND_THEN_AWAIT[3:1];

    // ----------
    // ahb address phase capture and answer
    // ----------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ap_q <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            ap_q.active <= addr_take;
            ap_q.write <= hwrite;
            ap_q.addr <= haddr[11:0];
            hreadyout <= 1'b1; // zero wait states
            hresp <= 1'b0; // always okay
        end
    end

    // ----------
    // read data, registered from the address phase
    // ----------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_take && !hwrite) begin
            hrdata <= 32'h0000_0000; // unmapped reads zero
            if (haddr[11:0] == cmb_pkg::OFS_CONFIG) begin
                hrdata[cmb_pkg::CFG_LOCK_BIT] <= lock_q;
            end else if (haddr[11:0] == cmb_pkg::OFS_SHARED_MASK) begin
                hrdata <= shared_mask_q;
            end else if (haddr[11:0] == cmb_pkg::OFS_CATCHALL_MASK) begin
                hrdata <= catchall_mask_q;
            end else if (haddr[11:0] == cmb_pkg::OFS_ENGINE_STATE) begin
                hrdata[9:0] <= {copy_q, copy_buf_q, tx_active_q, tx_buf_q};
            end else if (haddr[11:6] == cmb_pkg::OFS_STATUS_BASE[11:6] && 32'(haddr[5:2]) < NBUF) begin
                hrdata[8:0] <= status_q[haddr[5:2]];
            end else if (haddr[11:6] == cmb_pkg::OFS_ID_BASE[11:6] && 32'(haddr[5:2]) < NBUF) begin
                hrdata <= id_q[haddr[5:2]];
            end
        end
    end

    // ----------
    // configuration and masks
    // ----------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lock_q <= 1'b0;
            shared_mask_q <= cmb_pkg::MASK_RESET;
            catchall_mask_q <= cmb_pkg::MASK_RESET;
        end else if (wr_now) begin
            if (ap_q.addr == cmb_pkg::OFS_CONFIG) begin
                lock_q <= hwdata[cmb_pkg::CFG_LOCK_BIT];
            end
            if (ap_q.addr == cmb_pkg::OFS_SHARED_MASK) begin
                shared_mask_q <= hwdata;
            end
            if (ap_q.addr == cmb_pkg::OFS_CATCHALL_MASK) begin
                catchall_mask_q <= hwdata;
            end
        end
    end

    // ----------
    // hidden receive buffer
    // ----------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            receiving_q <= 1'b0;
            hidden_q <= '0;
        end else begin
            if (rx_sof) begin
                receiving_q <= 1'b1;
            end else if (rx_eof6) begin
                receiving_q <= 1'b0;
            end
            if (rx_eof6 && receiving_q) begin
                hidden_q.id_word <= rx_id_word;
                hidden_q.valid <= 1'b1;
            end else if (hidden_q.valid && !copy_q) begin
                hidden_q.valid <= 1'b0; // matched once, then released
            end
        end
    end

    // ----------
    // copy engine
    // ----------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            copy_q <= 1'b0;
            copy_buf_q <= 4'h0;
            copy_cnt_q <= 5'h00;
        end else if (start_copy) begin
            copy_q <= 1'b1;
            copy_buf_q <= rx_idx;
            copy_cnt_q <= 5'h00;
        end else if (copy_done) begin
            copy_q <= 1'b0;
        end else if (copy_q) begin
            copy_cnt_q <= copy_cnt_q + 5'h01;
        end
    end

    // ----------
    // identifier words
    // ----------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < NBUF; i++) begin
                id_q[i] <= cmb_pkg::ID_RESET;
            end
        end else begin
            if (wr_id && !(copy_q && wr_idx == copy_buf_q)
                    && !(tx_active_q && wr_idx == tx_buf_q)) begin
                id_q[wr_idx] <= hwdata;
            end
            if (copy_done) begin
                id_q[copy_buf_q] <= hidden_q.id_word; // whole frame copied
            end
        end
    end

    // ----------
    // transmit engine
    // ----------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_active_q <= 1'b0;
            tx_buf_q <= 4'h0;
            tx_req <= 1'b0;
            tx_id_word <= 32'h0000_0000;
        end else if (tx_active_q) begin
            if (tx_ok || tx_cancel) begin
                tx_active_q <= 1'b0;
                tx_req <= 1'b0;
            end
            // a failed attempt keeps the request standing
        end else if (tx_pick) begin
            tx_active_q <= 1'b1;
            tx_buf_q <= tx_pick_idx;
            tx_req <= 1'b1;
            tx_id_word <= id_q[tx_pick_idx];
        end
    end

    // ----------
    // status words
    // ----------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < NBUF; i++) begin
                status_q[i] <= {5'h00, cmb_pkg::ST_RX_IDLE};
            end
        end else begin
            // software write: busy bit never writable
            if (wr_status) begin
                status_q[wr_idx][3:1] <= hwdata[3:1];
                if (!(copy_q && wr_idx == copy_buf_q) && !(tx_active_q && wr_idx == tx_buf_q)) begin
                    status_q[wr_idx][8:4] <= hwdata[8:4];
                end
            end
            // remote frame wakes awaiting transmit buffers
            if (hidden_q.valid && !copy_q) begin
                for (int i = 0; i < NBUF; i++) begin
                    if (remote_hits[i]) begin
                        status_q[i][3:0] <= cmb_pkg::ST_TX_SEND_THEN_AWAIT;
                    end
                end
            end
            // copy start raises busy on the target
            if (start_copy) begin
                status_q[rx_idx][cmb_pkg::STS_BUSY_BIT] <= 1'b1;
            end
            // copy end resolves the final code
            if (copy_done) begin
                status_q[copy_buf_q][cmb_pkg::STS_BUSY_BIT] <= 1'b0;
                case (base_code)
                    cmb_pkg::ST_RX_ARMED[3:1]: begin
                        status_q[copy_buf_q][3:1] <= cmb_pkg::ST_RX_HOLDING[3:1];
                    end
                    cmb_pkg::ST_RX_HOLDING[3:1], cmb_pkg::ST_RX_OVERWRITTEN[3:1]: begin
                        status_q[copy_buf_q][3:1] <= cmb_pkg::ST_RX_OVERWRITTEN[3:1];
                    end
                    default: begin
                        status_q[copy_buf_q][3:1] <= base_code; // rx_idle stays
                    end
                endcase
            end
            // transmit start shows in-progress
            if (!tx_active_q && tx_pick) begin
                status_q[tx_pick_idx][cmb_pkg::STS_BUSY_BIT] <= 1'b1;
            end
            if (tx_cancel) begin
                status_q[tx_buf_q][cmb_pkg::STS_BUSY_BIT] <= 1'b0;
            end else if (tx_active_q && tx_ok) begin
                if (status_q[tx_buf_q][3:1] == cmb_pkg::ST_TX_SEND_THEN_AWAIT[3:1]) begin
                    status_q[tx_buf_q][3:0] <= cmb_pkg::ST_TX_AWAIT_REMOTE;
                end else if (tx_id_word[cmb_pkg::ID_RTR_BIT]) begin
                    status_q[tx_buf_q][3:0] <= cmb_pkg::ST_RX_ARMED;
                end else begin
                    status_q[tx_buf_q][3:0] <= cmb_pkg::ST_TX_IDLE;
                end
            end
            // tx_fail leaves the buffer in progress for retry
        end
    end

    // ----------
    // link-side indications
    // ----------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_busy <= 1'b0;
            rx_notify <= 1'b0;
            rx_notify_buf <= 4'h0;
        end else begin
            rx_busy <= start_copy || (copy_q && !copy_done);
            rx_notify <= copy_done && base_code == cmb_pkg::ST_RX_ARMED[3:1]
                && status_q[copy_buf_q][cmb_pkg::STS_NOTIFY_BIT];
            rx_notify_buf <= copy_buf_q;
        end
    end

endmodule // cmb_buffer_ctrl

// ### verification/cmb_buffer_ctrl_checker.sv
`timescale 1ns/10ps
// watches copy, notify and transmit timing at the ports
module cmb_buffer_ctrl_checker (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic rx_sof,
    input wire logic rx_eof6,
    input wire logic tx_ok,
    input wire logic tx_fail,
    input wire logic tx_req,
    input wire logic [3:0] tx_buf,
    input wire logic rx_busy,
    input wire logic rx_notify
);
    logic [5:0] cnt_q; // cycles of the running copy
    logic sof_q; // start seen, frame not yet valid
    logic eof_ok; // valid frame end after a start
    assign eof_ok = rx_eof6 && sof_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // copy length counter and frame tracker
    always_ff @(posedge ref_clk) begin
        cnt_q <= (rst || !rx_busy) ? 6'h00 : cnt_q + 6'h01;
        sof_q <= rst ? 1'b0 : (rx_sof || (sof_q && !rx_eof6));
    end
    property p_bus_ok; hreadyout && !hresp; endproperty
    a_bus_ok: assert property (p_bus_ok) else $error("bus not ready or not okay");
    property p_copy_len; (!rx_busy && cnt_q != 6'h00) |-> cnt_q >= 6'h11; endproperty
    a_copy_len: assert property (p_copy_len) else $error("copy shorter than allowed");
    property p_copy_cause; $rose(rx_busy) |-> $past(eof_ok, 2); endproperty
    a_copy_cause: assert property (p_copy_cause) else $error("copy without valid frame");
    property p_busy_hold; $rose(rx_busy) |-> rx_busy [*8]; endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
    property p_notify_cause; rx_notify |-> !rx_busy && ($past(rx_busy) || $past(rx_busy, 2)); endproperty
    a_notify_cause: assert property (p_notify_cause) else $error("notify not at copy end");
    property p_notify_pulse; rx_notify |=> !rx_notify; endproperty
    a_notify_pulse: assert property (p_notify_pulse) else $error("notify longer than a cycle");
    property p_retry; tx_fail && tx_req |=> tx_req && $stable(tx_buf); endproperty
    a_retry: assert property (p_retry) else $error("failed send not retried");
    property p_tx_done; tx_ok && tx_req |=> !tx_req; endproperty
    a_tx_done: assert property (p_tx_done) else $error("request kept after success");
endmodule // cmb_buffer_ctrl_checker

bind cmb_buffer_ctrl cmb_buffer_ctrl_checker u_chk (.ref_clk, .rst, .hreadyout, .hresp, .rx_sof, .rx_eof6,
    .tx_ok, .tx_fail, .tx_req, .tx_buf, .rx_busy, .rx_notify);

// ### verification/cmb_link_model.sv
`timescale 1ns/10ps
// far side of the can link: frames in, send results out
module cmb_link_model (
    input wire logic ref_clk,
    input wire logic send,
    input wire logic [31:0] id,
    input wire logic [1:0] nfail,
    input wire logic [3:0] lag,
    input wire logic tx_req,
    output logic rx_sof,
    output logic rx_eof6,
    output logic [31:0] rx_id_word,
    output logic tx_ok,
    output logic tx_fail
);
    // frame: start bit, body of lag cycles, then valid point
    initial begin
        {rx_sof, rx_eof6} = 2'h0;
        rx_id_word = 32'h0;
        forever begin
            @(posedge ref_clk);
            if (send) begin
                rx_sof <= 1'b1;
                @(posedge ref_clk);
                rx_sof <= 1'b0;
                repeat (lag) @(posedge ref_clk);
                rx_eof6 <= 1'b1;
                rx_id_word <= id;
                @(posedge ref_clk);
                rx_eof6 <= 1'b0;
                rx_id_word <= ~id; // stale id not held
            end
        end
    end
    // transmit: nfail failed attempts, then success
    initial begin
        {tx_ok, tx_fail} = 2'h0;
        forever begin
            @(posedge ref_clk);
            if (tx_req === 1'b1) begin
                repeat (nfail) begin
                    repeat (lag) @(posedge ref_clk);
                    tx_fail <= 1'b1;
                    @(posedge ref_clk);
                    tx_fail <= 1'b0;
                end
                repeat (lag) @(posedge ref_clk);
                tx_ok <= 1'b1;
                @(posedge ref_clk);
                tx_ok <= 1'b0;
            end
        end
    end
endmodule // cmb_link_model

// ### verification/testbench.sv
`timescale 1ns/10ps
module testbench;
    localparam logic [11:0] SB = cmb_pkg::OFS_STATUS_BASE;
    localparam logic [11:0] IB = cmb_pkg::OFS_ID_BASE;
    logic ref_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, send = 1'b0, txq = 1'b0;
    logic [1:0] htrans = 2'h0, nfail = 2'h0;
    logic [3:0] lag = 4'h2, tc, tx_buf, rx_notify_buf;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, mid = 32'h0, rd, id, hrdata, tx_id_word, rx_id_word;
    logic hreadyout, hresp, rx_sof, rx_eof6, tx_ok, tx_fail, tx_req, rx_busy, rx_notify;
    logic [3:0] wv[3] = '{4'h2, 4'h0, 4'h4}; // codes written mid-copy
    logic [3:0] lb[3] = '{4'h0, 4'h1, 4'hE}; // buffers sharing one id
    int fails = 0, n_compared = 0, n_note = 0, n_tx = 0, n0;
    always #25 ref_clk = ~ref_clk;
    // notify and transmit start counters
    always @(posedge ref_clk) begin
        txq <= tx_req;
        if (rx_notify === 1'b1) n_note++;
        if (tx_req === 1'b1 && txq !== 1'b1) n_tx++;
    end
    cmb_buffer_ctrl u_dut (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .rx_sof, .rx_eof6, .rx_id_word, .tx_ok, .tx_fail, .tx_req, .tx_buf,
        .tx_id_word, .rx_busy, .rx_notify, .rx_notify_buf);
    cmb_link_model u_link (.ref_clk, .send, .id(mid), .nfail, .lag, .tx_req, .rx_sof, .rx_eof6, .rx_id_word,
        .tx_ok, .tx_fail);
    function automatic logic [31:0] ra(input logic [11:0] b, input int n);
        return {20'h0, b} + 32'(4 * n);
    endfunction
    // final code after a write during a copy
    function automatic logic [3:0] rx_final(input logic [3:0] w);
        if (w == cmb_pkg::ST_RX_ARMED) return cmb_pkg::ST_RX_HOLDING;
        return (w == cmb_pkg::ST_RX_HOLDING) ? cmb_pkg::ST_RX_OVERWRITTEN : w;
    endfunction
    // code after a successful send
    function automatic logic [3:0] tx_final(input logic rtr, input logic [3:0] c);
        if (c == cmb_pkg::ST_TX_SEND_THEN_AWAIT) return cmb_pkg::ST_TX_AWAIT_REMOTE;
        return rtr ? cmb_pkg::ST_RX_ARMED : cmb_pkg::ST_TX_IDLE;
    endfunction
    // one single ahb-lite transfer, read data into rd
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdc(input logic [31:0] a);
        bus(1'b0, a, 32'h0);
        rd = rd & 32'hF;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // send a frame, return once the copy is under way
    task automatic frame(input logic [31:0] v);
        send <= 1'b1;
        mid <= v;
        @(posedge ref_clk);
        send <= 1'b0;
        for (int i = 0; i < 40 && rx_busy !== 1'b1; i++) @(posedge ref_clk);
    endtask
    task automatic settle;
        for (int i = 0; i < 300 && (rx_busy !== 1'b0 || tx_req !== 1'b0); i++) @(posedge ref_clk);
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        end_sim;
    end
    initial begin
        rd = $urandom(32'hC31B);
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        for (int n = 0; n < 16; n++) begin
            bus(1'b0, n < 15 ? ra(SB, n) : 32'h100, 32'h0);
            chk(rd, 32'h0);
        end
        $display("reset test done");
        bus(1'b1, 32'h4, 32'hFF);
        for (int k = 0; k < 3; k++) begin
            id = $urandom & 32'h7FFF_FFFF;
            bus(1'b1, ra(IB, 3), id ^ 32'h5A);
            bus(1'b1, ra(SB, 3), 32'h102);
            frame(id);
            rdc(ra(SB, 3));
            chk(rd, 32'h3);
            bus(1'b1, ra(IB, 3), 32'h0);
            bus(1'b1, ra(SB, 3), {28'h0, wv[k]});
            settle;
            bus(1'b0, ra(SB, 3), 32'h0);
            chk(rd, 32'h100 | 32'(rx_final(wv[k])));
            bus(1'b0, ra(IB, 3), 32'h0);
            if (wv[k] != 4'h0) chk(rd, id);
        end
        bus(1'b1, ra(SB, 3), 32'h102);
        for (int j = 0; j < 2; j++) begin
            frame(id);
            rdc(ra(SB, 3));
            chk(rd, j ? 32'h5 : 32'h3);
            settle;
            rdc(ra(SB, 3));
            chk(rd, j ? 32'h6 : 32'h4);
        end
        chk(32'(n_note), 32'h2);
        chk(32'(rx_notify_buf), 32'h3);
        $display("receive test done");
        id = $urandom & 32'h7FFF_FF00;
        bus(1'b1, 32'h0, 32'h1);
        for (int b = 0; b < 3; b++) begin
            bus(1'b1, ra(IB, lb[b]), id);
            bus(1'b1, ra(SB, lb[b]), 32'h2);
        end
        for (int f = 0; f < 4; f++) begin
            frame(id);
            settle;
            for (int b = 0; b < 3; b++) begin
                rdc(ra(SB, lb[b]));
                chk(rd, b <= f ? 32'h4 : 32'h2);
            end
        end
        bus(1'b1, ra(SB, 0), 32'h2);
        frame(id);
        settle;
        rdc(ra(SB, 0));
        chk(rd, 32'h4);
        bus(1'b1, 32'h0, 32'h0);
        $display("lock test done");
        for (int t = 0; t < 3; t++) begin
            id = ($urandom & 32'h7FFF_FFFF) | (t == 1 ? 32'h8000_0000 : 32'h0);
            tc = (t == 2) ? cmb_pkg::ST_TX_SEND_THEN_AWAIT : cmb_pkg::ST_TX_SINGLE_SHOT;
            nfail <= 2'(t);
            lag <= 4'($urandom_range(12, 4));
            bus(1'b1, ra(IB, 2), id);
            bus(1'b1, ra(SB, 2), {28'h0, tc});
            for (int i = 0; i < 20 && tx_req !== 1'b1; i++) @(posedge ref_clk);
            chk(32'(tx_buf), 32'h2);
            chk(tx_id_word, id);
            rdc(ra(SB, 2));
            chk(rd, 32'(tc | 4'h1));
            settle;
            rdc(ra(SB, 2));
            chk(rd, 32'(tx_final(id[31], tc)));
        end
        nfail <= 2'h0;
        n0 = n_tx;
        bus(1'b1, 32'h4, 32'h8000_00FF);
        frame(id | 32'h8000_0000);
        settle;
        rdc(ra(SB, 2));
        chk(rd, 32'hA);
        chk(32'(n_tx - n0), 32'h1);
        $display("transmit test done");
        end_sim;
    end
endmodule // testbench
